// File: dac_device.sv
// Converter end: serial input, update control and output state
//
// Function
// - Commands are 24-bit words, MSB first
// - Data sampled on serial clock falling edge
// - Check bits make frames 32 bits long
// - Load low: addressed channel updates at frame end
// - Load high: only first write per channel counts
// - Load falling after frame updates the channels that hold a staged write
// - Codes are always straight binary
// - Bipolar ranges: midscale zero, full codes limits
// - Top four bits to 15 segments, 12 ladder
// - At most one output enabled per channel
// - Three current and four voltage ranges
// - Condition select low: all outputs high impedance
// - Condition select high: voltage pull-down, current off
// - Defaults 0-5 V, disabled, zero clear codes
// - Clear drives enabled channels to clear code
// - Host waits 100 us before first write
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "dac_regs.svh"
module dac_device (
  // Internal clock and power-on reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Serial link
  dac_link_if.device                   link,
  // Pins
  input  wire logic                    power_on_condition_sel,
  input  wire logic                    clear_req,
  // Channel outputs
  output logic      [3:0][15:0]        code_q,
  output logic      [3:0][15:0]        level_q,
  output logic      [3:0][14:0]        therm_q,
  output logic      [3:0][11:0]        ladder_q,
  output dac_pkg::range_t [3:0]        range_q,
  output logic      [3:0]              iout_en_q,
  output logic      [3:0]              vout_en_q,
  output logic      [3:0]              vout_pd_q,
  output logic                         packet_check_q
);

  // ****************************************
  // Link clock domain
  // ****************************************
  logic [31:0] shift_q;
  logic [5:0]  cnt_q;
  logic        fresh_q;

  always_ff @(negedge link.ser_clk)
  begin
    if (!link.frame_n)
    begin
      shift_q <= {shift_q[30:0], link.ser_data};
    end
  end

  // Marks the first edge of a frame; armed by the frame signal itself
  always_ff @(negedge link.ser_clk or posedge link.frame_n)
  begin
    if (link.frame_n)
    begin
      fresh_q <= 1'b1;
    end
    else
    begin
      fresh_q <= 1'b0;
    end
  end

  // Count survives frame end so the other domain can read it
  always_ff @(negedge link.ser_clk)
  begin
    if (!link.frame_n)
    begin
      if (fresh_q)
      begin
        cnt_q <= 6'd1;
      end
      else if (cnt_q != 6'h3f)
      begin
        cnt_q <= cnt_q + 6'd1;
      end
    end
  end

  // ****************************************
  // Synchronisers
  // ****************************************
  logic [2:0] fr_q;
  logic [2:0] ld_q;
  logic [2:0] cl_q;
  logic [1:0] cond_s_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fr_q    <= 3'b111;
      ld_q    <= 3'b111;
      cl_q    <= 3'b000;
    end
    else
    begin
      fr_q    <= {fr_q[1:0], link.frame_n};
      ld_q    <= {ld_q[1:0], link.load_outputs_n};
      cl_q    <= {cl_q[1:0], clear_req};
    end
  end

  // No reset: must already hold the pin level when reset lifts
  always_ff @(posedge aclk)
  begin
    cond_s_q <= {cond_s_q[0], power_on_condition_sel};
  end

  // ****************************************
  // Frame decode
  // ****************************************
  logic        fr_rise;
  logic        len_ok;
  logic [23:0] word;
  logic [1:0]  ch;
  logic        ld_fall;
  logic        clr_rise;

  // Shift and count are static here: the frame ended and the clock halted
  always_comb
  begin
    fr_rise  = fr_q[1] & ~fr_q[2];
    len_ok   = (cnt_q == (packet_check_q ? `CHK_BITS : `WORD_BITS));
    word     = packet_check_q ? shift_q[31:8] : shift_q[23:0];
    ch       = word[`CH_MSB:`CH_LSB];
    ld_fall  = ld_q[2] & ~ld_q[1] & fr_q[2];
    clr_rise = cl_q[1] & ~cl_q[2];
  end

  function automatic logic is_cmd(input logic [23:0] w, input dac_pkg::cmd_t c);
    is_cmd = (w[`CMD_MSB:`CMD_LSB] == c);
  endfunction

  // ****************************************
  // Configuration
  // ****************************************
  logic [3:0]       iout_sel_q;
  logic [3:0]       out_en_q;
  logic [3:0]       clr_en_q;
  logic [3:0][15:0] clr_code_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      range_q        <= '{default: dac_pkg::range_t'(`RANGE_RST)};
      iout_sel_q     <= 4'h0;
      out_en_q       <= 4'h0;
      clr_en_q       <= 4'h0;
      clr_code_q     <= {4{`CODE_RST}};
      packet_check_q <= 1'b0;
    end
    else if (fr_rise && len_ok)
    begin
      if (is_cmd(word, dac_pkg::CMD_CTRL))
      begin
        range_q[ch]    <= dac_pkg::range_t'(word[`CTL_RANGE_MSB:0]);
        iout_sel_q[ch] <= word[`CTL_IOUT_BIT];
        out_en_q[ch]   <= word[`CTL_OUTEN_BIT];
        clr_en_q[ch]   <= word[`CTL_CLREN_BIT];
      end
      if (is_cmd(word, dac_pkg::CMD_CLRCODE))
      begin
        clr_code_q[ch] <= word[`DATA_MSB:0];
      end
      if (is_cmd(word, dac_pkg::CMD_SOFT))
      begin
        packet_check_q <= word[`SW_CHK_BIT];
      end
    end
  end

  // ****************************************
  // Data and update
  // ****************************************
  logic [3:0][15:0] data_q;
  logic [3:0][15:0] stage_q;
  logic [3:0]       taken_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_q  <= {4{`CODE_RST}};
      stage_q <= {4{`CODE_RST}};
      taken_q <= 4'h0;
      code_q  <= {4{`CODE_RST}};
    end
    else
    begin
      if (ld_fall)
      begin
        for (int c = 0; c < 4; c++)
        begin
          if (taken_q[c])
          begin
            code_q[c] <= stage_q[c];
          end
        end
        taken_q <= 4'h0;
      end
      if (clr_rise)
      begin
        for (int c = 0; c < 4; c++)
        begin
          if (clr_en_q[c])
          begin
            code_q[c] <= clr_code_q[c];
          end
        end
      end
      // Placed last so a direct write in the same cycle wins over a clear
      if (fr_rise && len_ok && is_cmd(word, dac_pkg::CMD_DATA))
      begin
        data_q[ch] <= word[`DATA_MSB:0];
        if (!ld_q[2])
        begin
          code_q[ch] <= word[`DATA_MSB:0];
        end
        else if (!taken_q[ch])
        begin
          stage_q[ch] <= word[`DATA_MSB:0];
          taken_q[ch] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Power-on condition capture
  // ****************************************
  logic cond_q;
  logic rel_q;

  // Taken once, at the first edge after release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rel_q  <= 1'b0;
      cond_q <= 1'b0;
    end
    else if (!rel_q)
    begin
      rel_q  <= 1'b1;
      cond_q <= cond_s_q[1];
    end
  end

  // ****************************************
  // Output stage
  // ****************************************
  logic [3:0][14:0] therm;
  logic [3:0][11:0] ladder;

  for (genvar g = 0; g < 4; g++)
  begin : g_dec
    seg_decode u_dec (
      .code   (code_q[g]),
      .therm  (therm[g]),
      .ladder (ladder[g])
    );
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      iout_en_q <= 4'h0;
      vout_en_q <= 4'h0;
      vout_pd_q <= 4'h0;
      level_q   <= {4{`CODE_RST}};
      therm_q   <= '0;
      ladder_q  <= '0;
    end
    else
    begin
      for (int c = 0; c < 4; c++)
      begin
        iout_en_q[c] <= out_en_q[c] & iout_sel_q[c];
        vout_en_q[c] <= out_en_q[c] & ~iout_sel_q[c];
        vout_pd_q[c] <= cond_q & ~(out_en_q[c] & ~iout_sel_q[c]);
        // Bipolar: offset from midscale, two's complement level
        if (range_q[c] == dac_pkg::RNG_VPM5 || range_q[c] == dac_pkg::RNG_VPM10)
        begin
          level_q[c] <= code_q[c] ^ `BIPOLAR_FLIP;
        end
        else
        begin
          level_q[c] <= code_q[c];
        end
        therm_q[c]  <= therm[c];
        ladder_q[c] <= ladder[c];
      end
    end
  end

endmodule

// File: dac_host.sv
// Host end: register-driven serial frame generator
`timescale 1ns/1ps
`include "dac_regs.svh"
module dac_host (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Serial link
  dac_link_if.host         link
);

  dac_pkg::host_state_t st_q;
  logic [1:0]  ctrl_q;
  logic [23:0] tx_q;
  logic [7:0]  chk_q;
  logic        pend_q;
  logic [11:0] pwr_q;
  logic        ready_q;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  waddr_q;
  logic [31:0] wdat_q;
  logic [3:0]  wstb_q;
  logic        busy;
  logic        do_wr;

  assign busy  = pend_q | (st_q != dac_pkg::S_IDLE);
  assign do_wr = aw_hold_q & w_hold_q & ~bvalid;

  // ****************************************
  // Power-up wait
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwr_q   <= 12'd0;
      ready_q <= 1'b0;
    end
    else if (!ready_q)
    begin
      pwr_q   <= pwr_q + 12'd1;
      ready_q <= (pwr_q == 12'(`PWRUP_CYC - 1));
    end
  end

  // ****************************************
  // Write channel
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      waddr_q   <= 8'h00;
      wdat_q    <= 32'h0000_0000;
      wstb_q    <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
    end
    else
    begin
      awready <= ~(aw_hold_q | (awvalid & awready)) & ~bvalid & ~do_wr;
      wready  <= ~(w_hold_q | (wvalid & wready)) & ~bvalid & ~do_wr;
      if (awvalid && awready)
      begin
        aw_hold_q <= 1'b1;
        waddr_q   <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold_q <= 1'b1;
        wdat_q   <= wdata;
        wstb_q   <= wstrb;
      end
      if (do_wr)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (waddr_q == `REG_STAT || waddr_q > `REG_STAT) ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `HCTL_RST;
      tx_q   <= 24'h00_0000;
      chk_q  <= 8'h00;
      pend_q <= 1'b0;
    end
    else
    begin
      if (st_q == dac_pkg::S_IDLE && pend_q && ready_q)
      begin
        pend_q <= 1'b0;
      end
      // Writes while a frame is queued or running are dropped
      if (do_wr && wstb_q[0])
      begin
        if (waddr_q == `REG_CTRL && !busy)
        begin
          ctrl_q <= wdat_q[1:0];
        end
        if (waddr_q == `REG_CHECK && !busy)
        begin
          chk_q <= wdat_q[7:0];
        end
        if (waddr_q == `REG_TX && !busy)
        begin
          tx_q   <= wdat_q[23:0];
          pend_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end
    else
    begin
      arready <= ~(arvalid & arready) & ~rvalid;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp  <= `RESP_OKAY;
        case (araddr)
          `REG_CTRL:  rdata <= {30'd0, ctrl_q};
          `REG_TX:    rdata <= {8'd0, tx_q};
          `REG_CHECK: rdata <= {24'd0, chk_q};
          `REG_STAT:  rdata <= {30'd0, ready_q, busy};
          default:
          begin
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Frame generator
  // ****************************************
  logic [31:0] sh_q;
  logic [5:0]  bits_q;
  logic [1:0]  half_q;
  logic        chk_on;

  assign chk_on = ctrl_q[`HCTL_CHK_BIT];

  // Data changes on the rising clock so it is steady at the falling one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q                <= dac_pkg::S_IDLE;
      link.frame_n        <= 1'b1;
      link.ser_clk        <= 1'b1;
      link.ser_data       <= 1'b0;
      link.load_outputs_n <= 1'b1;
      sh_q                <= 32'h0000_0000;
      bits_q              <= 6'd0;
      half_q              <= 2'd0;
    end
    else
    begin
      case (st_q)
        dac_pkg::S_IDLE:
        begin
          if (!pend_q)
          begin
            link.load_outputs_n <= ctrl_q[`HCTL_LD_BIT];
          end
          if (pend_q && ready_q)
          begin
            st_q          <= dac_pkg::S_SHIFT;
            link.frame_n  <= 1'b0;
            sh_q          <= {tx_q, chk_on ? chk_q : 8'h00};
            link.ser_data <= tx_q[23];
            bits_q        <= chk_on ? `CHK_BITS : `WORD_BITS;
            half_q        <= 2'd0;
          end
        end
        dac_pkg::S_SHIFT:
        begin
          half_q <= half_q + 2'd1;
          if (half_q == `SCLK_HALF)
          begin
            half_q       <= 2'd0;
            link.ser_clk <= ~link.ser_clk;
            if (!link.ser_clk)
            begin
              sh_q          <= {sh_q[30:0], 1'b0};
              link.ser_data <= sh_q[30];
              bits_q        <= bits_q - 6'd1;
              if (bits_q == 6'd1)
              begin
                st_q         <= dac_pkg::S_GAP;
                link.frame_n <= 1'b1;
                bits_q       <= `GAP_CYC;
              end
            end
          end
        end
        dac_pkg::S_GAP:
        begin
          bits_q <= bits_q - 6'd1;
          if (bits_q == 6'd1)
          begin
            st_q <= dac_pkg::S_IDLE;
          end
        end
        default: st_q <= dac_pkg::S_IDLE;
      endcase
    end
  end

endmodule

// File: dac_link_if.sv
// Serial link between the host controller and the converter
`timescale 1ns/1ps
interface dac_link_if;
  logic ser_clk;
  logic frame_n;
  logic ser_data;
  logic load_outputs_n;

  modport device (
    input ser_clk,
    input frame_n,
    input ser_data,
    input load_outputs_n
  );

  modport host (
    output ser_clk,
    output frame_n,
    output ser_data,
    output load_outputs_n
  );
endinterface

// File: dac_link_monitor.sv
// Protocol checker for the serial converter link
`timescale 1ns/1ps
module dac_link_monitor (
  // Host clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link wires
  input wire logic ser_clk,
  input wire logic frame_n,
  input wire logic ser_data,
  input wire logic load_outputs_n
);
  logic [5:0] bits_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ********************************
  // Falling clock edges in a frame
  // ********************************
  always_ff @(posedge aclk)
    if (!aresetn || frame_n)
      bits_q <= 6'h00;
    else if ($fell(ser_clk))
      bits_q <= bits_q + 6'h01;

  // ********************************
  // Link properties
  // ********************************
  idle_clk_high_a: assert property (frame_n |-> ser_clk)
    else $error("serial clock low outside a frame");
  data_hold_a: assert property ($fell(ser_clk) |-> $stable(ser_data) ##1 $stable(ser_data))
    else $error("serial data moved around the sampling edge");
  word_len_a: assert property ($rose(frame_n) |-> bits_q == 6'd24 || bits_q == 6'd32)
    else $error("frame closed without 24 or 32 bits");
  half_period_a: assert property (!frame_n && $fell(ser_clk) |-> ##1 !ser_clk ##1 ser_clk)
    else $error("serial clock low phase not two cycles");
  frame_close_a: assert property ($rose(frame_n) |-> $rose(ser_clk))
    else $error("frame closed away from the last clock rise");
  frame_gap_a: assert property ($rose(frame_n) |-> frame_n [*8])
    else $error("frame gap shorter than eight cycles");
  load_idle_a: assert property ($changed(load_outputs_n) |-> frame_n && $past(frame_n))
    else $error("load strobe moved inside a frame");
  first_edge_a: assert property ($fell(frame_n) |-> ##[1:2] $fell(ser_clk))
    else $error("no sampling edge after frame start");
  frame_span_a: assert property ($fell(frame_n) |-> ##[90:140] $rose(frame_n))
    else $error("frame length out of range");
endmodule

// File: dac_pkg.sv
// Types shared by both ends of the converter link
package dac_pkg;

  typedef enum logic [2:0] {
    RNG_V0_5   = 3'd0,
    RNG_V0_10  = 3'd1,
    RNG_VPM5   = 3'd2,
    RNG_VPM10  = 3'd3,
    RNG_I4_20  = 3'd4,
    RNG_I0_20  = 3'd5,
    RNG_I0_24  = 3'd6
  } range_t;

  typedef enum logic [3:0] {
    CMD_DATA    = 4'h1,
    CMD_CTRL    = 4'h2,
    CMD_CLRCODE = 4'h3,
    CMD_SOFT    = 4'h4
  } cmd_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_SHIFT = 3'b010,
    S_GAP   = 3'b100
  } host_state_t;

endpackage

// File: dac_regs.svh
// Constants for the serial converter link and the host register map
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH

// Frame lengths in serial clocks
`define WORD_BITS     6'd24
`define CHK_BITS      6'd32

// Command word fields
`define CMD_MSB       23
`define CMD_LSB       20
`define CH_MSB        17
`define CH_LSB        16
`define DATA_MSB      15

// Control and software command fields
`define CTL_RANGE_MSB 2
`define CTL_IOUT_BIT  3
`define CTL_OUTEN_BIT 4
`define CTL_CLREN_BIT 5
`define SW_CHK_BIT    0

// Reset values and bipolar flip mask
`define RANGE_RST     3'd0
`define CODE_RST      16'h0000
`define BIPOLAR_FLIP  16'h8000

// Timing
`define CLK_NS        25
`define PWRUP_NS      100000
`define PWRUP_CYC     ((`PWRUP_NS + `CLK_NS - 1) / `CLK_NS)
`define SCLK_HALF     2'd1
`define GAP_CYC       6'd8

// Host register offsets and fields
`define REG_CTRL      8'h00
`define REG_TX        8'h04
`define REG_CHECK     8'h08
`define REG_STAT      8'h0c
`define HCTL_CHK_BIT  0
`define HCTL_LD_BIT   1
`define HCTL_RST      2'b10
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

// File: quad_dac_serial_load_update_test.sv
// Self-checking bench for both ends of the converter link
`timescale 1ns/1ps
module quad_dac_serial_load_update_test;
  logic                  aclk, dev_clk, aresetn, power_on_condition_sel, clear_req;
  logic [7:0]            awaddr, araddr;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, packet_check_q;
  logic [31:0]           wdata, rdata, s;
  logic [3:0]            wstrb, iout_en_q, vout_en_q, vout_pd_q;
  logic [1:0]            bresp, rresp, r;
  logic [3:0][15:0]      code_q, level_q;
  logic [3:0][14:0]      therm_q;
  logic [3:0][11:0]      ladder_q;
  dac_pkg::range_t [3:0] range_q;
  logic [15:0]           pat [5] = '{16'hffff, 16'h8000, 16'h0000, 16'h7fff, 16'h0001};
  int                    n_errors, n_checks, n;
  int                    code_m [4], stg_m [4], rng_m [4], clr_m [4];
  bit                    staged [4], iout_m [4], outen_m [4], clren_m [4];
  bit                    pc_m, hpc_m, load_hi, cond_m;
  logic [31:0]           seed;

  dac_link_if link ();
  dac_host u_dac_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .link(link));
  // Converter runs from its own dev_clk, unrelated to the host clock
  dac_device u_dac_device (.aclk(dev_clk), .aresetn(aresetn), .link(link),
    .power_on_condition_sel(power_on_condition_sel), .clear_req(clear_req), .code_q(code_q),
    .level_q(level_q), .therm_q(therm_q), .ladder_q(ladder_q), .range_q(range_q), .iout_en_q(iout_en_q),
    .vout_en_q(vout_en_q), .vout_pd_q(vout_pd_q), .packet_check_q(packet_check_q));
  dac_link_monitor u_dac_link_monitor (.aclk(aclk), .aresetn(aresetn), .ser_clk(link.ser_clk),
    .frame_n(link.frame_n), .ser_data(link.ser_data), .load_outputs_n(link.load_outputs_n));

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial
  begin
    dev_clk = 1'b0;
    #3.7;
    forever #6 dev_clk = ~dev_clk;
  end

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic step(inout int k);
    @(posedge aclk);
    k++;
    if (k > 5000)
    begin
      n_errors++;
      $display("FAIL wait expected done seen timeout");
      complete_run();
    end
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_chan(input int c);
    logic [15:0] cd;
    logic [14:0] th;
    bit          bip, ve;
    cd = 16'(code_m[c]);
    bip = rng_m[c] == 2 || rng_m[c] == 3;
    ve = outen_m[c] && !iout_m[c];
    for (int i = 0; i < 15; i++)
      th[i] = cd[15:12] > i;
    check_word("code", {16'h0, cd}, {16'h0, code_q[c]});
    check_word("level", {16'h0, cd ^ (bip ? 16'h8000 : 16'h0)}, {16'h0, level_q[c]});
    check_word("therm", {17'h0, th}, {17'h0, therm_q[c]});
    check_word("ladder", {20'h0, cd[11:0]}, {20'h0, ladder_q[c]});
    check_word("range", rng_m[c], 32'(range_q[c]));
    check_word("enables", {29'h0, outen_m[c] && iout_m[c], ve, cond_m && !ve},
      {29'h0, iout_en_q[c], vout_en_q[c], vout_pd_q[c]});
  endtask

  task automatic check_all();
    for (int c = 0; c < 4; c++)
      check_chan(c);
    check_word("packet check", {31'h0, pc_m}, {31'h0, packet_check_q});
  endtask

  // ********************************
  // Bus and link transfers
  // ********************************
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      step(k);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (awvalid || wvalid);
    while (!bvalid)
      step(k);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      step(k);
    while (!arready);
    arvalid <= 1'b0;
    while (!rvalid)
      step(k);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic set_ctrl(input bit pc, input bit ld);
    axi_write(8'h00, {30'h0, ld, pc}, r);
    repeat (8) @(posedge aclk);
    if (load_hi && !ld)
      for (int c = 0; c < 4; c++)
        code_m[c] = staged[c] ? stg_m[c] : code_m[c];
    if (!ld)
      staged = '{default: 0};
    load_hi = ld;
    hpc_m = pc;
  endtask

  task automatic send(input logic [3:0] cmd, input logic [1:0] ch, input logic [15:0] d);
    int k;
    k = 0;
    if (hpc_m)
      axi_write(8'h08, rnd() & 32'hff, r);
    axi_write(8'h04, {8'h0, cmd, 2'b00, ch, d}, r);
    s = 32'h1;
    while (s[0])
    begin
      axi_read(8'h0c, s, r);
      step(k);
    end
    repeat (4) @(posedge aclk);
    // Device drops frames whose length does not match its check mode
    if (pc_m == hpc_m)
      case (cmd)
        dac_pkg::CMD_DATA:
          if (!load_hi)
            code_m[ch] = d;
          else if (!staged[ch])
          begin
            stg_m[ch] = d;
            staged[ch] = 1;
          end
        dac_pkg::CMD_CTRL:
          {clren_m[ch], outen_m[ch], iout_m[ch], rng_m[ch]} = {d[5], d[4], d[3], 29'h0, d[2:0]};
        dac_pkg::CMD_CLRCODE:
          clr_m[ch] = d;
        default:
          pc_m = d[0];
      endcase
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial
  begin
    seed = 32'h0000207f;
    {n_errors, n_checks} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clear_req} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    power_on_condition_sel = 1'b1;
    cond_m = 1;
    load_hi = 1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    check_all();
    axi_read(8'h00, s, r);
    check_word("ctrl reset", 32'h2, s);
    axi_read(8'h10, s, r);
    check_word("unmapped read", 32'h2, {30'h0, r});
    axi_write(8'h0c, 32'h1, r);
    check_word("read-only write", 32'h2, {30'h0, r});
    n = 0;
    while (!s[1])
    begin
      axi_read(8'h0c, s, r);
      step(n);
    end
    for (int i = 0; i < 7; i++)
    begin
      send(dac_pkg::CMD_CTRL, 2'(i), {10'h0, i[0], 1'b1, i >= 4, 3'(i)});
      check_chan(i % 4);
    end
    set_ctrl(0, 0);
    for (int i = 0; i < 10; i++)
    begin
      send(dac_pkg::CMD_DATA, i[0] ? 2'd2 : 2'd3, i < 9 ? pat[i / 2] : 16'(rnd()));
      check_all();
    end
    set_ctrl(0, 1);
    send(dac_pkg::CMD_DATA, 2'd0, 16'(rnd()));
    send(dac_pkg::CMD_DATA, 2'd0, 16'(rnd()));
    send(dac_pkg::CMD_DATA, 2'd1, 16'(rnd()));
    check_all();
    set_ctrl(0, 0);
    check_all();
    send(dac_pkg::CMD_SOFT, 2'd0, 16'h0001);
    set_ctrl(1, 0);
    send(dac_pkg::CMD_DATA, 2'd2, 16'(rnd()));
    check_all();
    set_ctrl(0, 0);
    send(dac_pkg::CMD_DATA, 2'd2, 16'(rnd()));
    check_all();
    set_ctrl(1, 0);
    send(dac_pkg::CMD_SOFT, 2'd0, 16'h0000);
    set_ctrl(0, 0);
    send(dac_pkg::CMD_CLRCODE, 2'd1, 16'(rnd()));
    clear_req <= 1'b1;
    repeat (8) @(posedge aclk);
    clear_req <= 1'b0;
    repeat (8) @(posedge aclk);
    for (int c = 0; c < 4; c++)
      code_m[c] = clren_m[c] ? clr_m[c] : code_m[c];
    check_all();
    power_on_condition_sel <= 1'b0;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    code_m = '{default: 0};
    stg_m = '{default: 0};
    rng_m = '{default: 0};
    clr_m = '{default: 0};
    iout_m = '{default: 0};
    outen_m = '{default: 0};
    clren_m = '{default: 0};
    {cond_m, pc_m} = '0;
    repeat (8) @(posedge aclk);
    check_all();
    complete_run();
  end
endmodule

// File: seg_decode.sv
// Splits a code into segment switch controls and ladder bits
`timescale 1ns/1ps
module seg_decode (
  // Code in
  input  wire logic [15:0] code,
  // Switch controls out
  output logic      [14:0] therm,
  output logic      [11:0] ladder
);

  always_comb
  begin
    for (int i = 0; i < 15; i++)
    begin
      therm[i] = (code[15:12] > i[3:0]);
    end
    ladder = code[11:0];
  end

endmodule
